// *** debs_params.svh ***
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef DEBS_PARAMS_SVH
`define DEBS_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DEBS_REG_CTRL 8'h00
`define DEBS_REG_VTHR 8'h04
`define DEBS_REG_TMO  8'h08
`define DEBS_REG_STAT 8'h0c
`define DEBS_REG_FLT  8'h10

// ****************************************************************
// Control fields
// ****************************************************************
`define DEBS_CTRL_SWEN 0
`define DEBS_CTRL_BIMM 1
`define DEBS_CTRL_UVM  2
`define DEBS_CTRL_DISM 3
`define DEBS_CTRL_BRKF 5

// ****************************************************************
// Fault and status fields
// ****************************************************************
`define DEBS_FLT_UV   0
`define DEBS_FLT_STO  1
`define DEBS_FLT_EXT  2
`define DEBS_STAT_WRN 8

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define DEBS_CTRL_RST  6'h24
`define DEBS_VTHR_RST  16'h0010
`define DEBS_TMO_US    1000
`define DEBS_CLK_MHZ   100
`define DEBS_TMO_RST   (`DEBS_TMO_US * `DEBS_CLK_MHZ)

`endif

// *** debs_pkg.sv ***
// Types shared by the drive enable and brake sequencer
package debs_pkg;

    typedef enum logic [2:0] {
        DEBS_OFF,
        DEBS_RUN,
        DEBS_DECEL,
        DEBS_COAST,
        DEBS_DYNBRK
    } debs_state_t;

    typedef enum logic [1:0] {
        DEBS_CAT0,
        DEBS_CAT1,
        DEBS_CAT2,
        DEBS_CATN
    } debs_cat_t;

    // Drive-side outputs
    typedef struct packed {
        logic      power_active;
        logic      decel_cmd;
        logic      dyn_brake;
        logic      brake_engage;
        logic      stopping;
        debs_cat_t stop_cat;
    } debs_drv_t;

    // Pin inputs: hardware_enable_input, sto, digital stop, cat0, cat1, undervoltage
    typedef struct packed {
        logic hw_en;
        logic safe_torque_off_input;
        logic dstop;
        logic cat0;
        logic cat1;
        logic uv;
    } debs_pins_t;

endpackage

// *** debs_sequencer.sv ***
// Drive enable, stop and holding brake sequencer with AXI4-Lite registers
//
// Notes on behaviour
// - Power stage active dropping always starts holding brake engagement.
// - In a stop, brake engages on low velocity or timeout, first wins.
// - Brake-immediate set engages brake at once on hw disable or on any fault except a controlled-class one.
// - Undervoltage mode 0 raises undervoltage fault whenever undervoltage.
// - Mode 1 (reset default) gives only a warning while not enabled.
// - Mode 1 faults on undervoltage while enabled or at enable request.
// - Torque-off open when hardware_enable_input rises raises fault, torque stays off.
// - Hardware_enable_input falling removes power at once; brake follows stop rules.
// - Disable mode 0 removes power at once; brake on threshold/timeout.
// - Disable mode 2 decelerates first, then removes power and engages brake in the same cycle.
// - Digital stop input decelerates, then disables and engages fitted brake in the same cycle.
// - Faults stop by class: immediate, dynamic braking or controlled.
// - Category 1 keeps power during deceleration, removes it when done.
// - Cat 0 and cat 1 act in every mode; cat 0 beats cat 1.
// - Any active stop request beats an enable request.
// - Stop status is reported on outputs and in a status register.
// - Emergency stop (cat 0 input) overrides every other function.
// - Clearing a stop or fault never re-enables; fresh enable needed.
// - Power allowed only while torque-off input is energised.
`timescale 1ns/1ns
`include "debs_params.svh"

module debs_sequencer
    import debs_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Asynchronous pins
    input  wire debs_pins_t  pins_in,
    // Same-clock drive logic
    input  wire logic [15:0] velocity,
    input  wire logic        fault_req,
    input  wire logic [1:0]  fault_class,
    // Power stage and brake
    output debs_drv_t        drv
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        debs_pins_t  s1;
        debs_pins_t  s2;
        logic        en_prev;
        logic        hw_prev;
        debs_state_t st;
        logic [23:0] cnt;
        logic        imm;
        logic        engaged;
        logic [5:0]  ctrl;
        logic [15:0] vthr;
        logic [23:0] tmo;
        logic [2:0]  flt;
        logic        warn;
        debs_drv_t   drv;
        logic        awr;
        logic        wr;
        logic        bv;
        logic [1:0]  br;
        logic        arr;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
    } debs_reg_t;

    debs_reg_t s_q;
    debs_reg_t s_d;

    logic        hw;
    logic        safe_torque_off_input;
    logic        swen;
    logic        uvm;
    logic [1:0]  dism;
    logic        en_lvl;
    logic        en_rise;
    logic        hw_rise;
    logic [15:0] vabs;
    logic        vslow;
    logic        tmo_hit;
    logic        act;
    logic        uv_f;
    logic        sto_f;
    logic        f_imm;
    logic        f_dyn;
    logic        f_ctl;
    logic        go0;
    logic        go1;
    logic        stop_req;
    logic        done;
    logic [2:0]  f_new;
    logic [2:0]  f_clr;
    logic [31:0] rdv;

    // ****************************************************************
    // Sequencer and register file
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;

        // Pins pass two flip-flops
        s_d.s1 = pins_in;
        s_d.s2 = s_q.s1;
        hw     = s_q.s2.hw_en;
        safe_torque_off_input    = s_q.s2.safe_torque_off_input;

        swen = s_q.ctrl[`DEBS_CTRL_SWEN];
        uvm  = s_q.ctrl[`DEBS_CTRL_UVM];
        dism = s_q.ctrl[`DEBS_CTRL_DISM +: 2];

        // Enable request is a fresh rise of both enables
        en_lvl     = hw & swen;
        en_rise    = en_lvl & ~s_q.en_prev;
        hw_rise    = hw & ~s_q.hw_prev;
        s_d.en_prev = en_lvl;
        s_d.hw_prev = hw;

        vabs  = velocity[15] ? 16'(-velocity) : velocity;
        vslow = vabs < s_q.vthr;
        tmo_hit = s_q.cnt >= s_q.tmo;
        act   = s_q.drv.power_active;

        // Undervoltage fault or warning
        uv_f = s_q.s2.uv & (~uvm | act | en_rise);
        s_d.warn = s_q.s2.uv & uvm & ~uv_f;

        sto_f = (hw_rise | act) & ~safe_torque_off_input;

        f_imm = fault_req & (fault_class == 2'h0);
        f_dyn = fault_req & (fault_class == 2'h1);
        f_ctl = fault_req & fault_class[1];

        // Category 0 causes
        go0 = s_q.s2.cat0 | ~hw | sto_f | uv_f | f_imm
            | (~swen & (dism != 2'h2));
        // Category 1 causes
        go1 = s_q.s2.cat1 | f_ctl | (~swen & (dism == 2'h2));
        stop_req = s_q.s2.cat0 | s_q.s2.cat1 | s_q.s2.dstop;

        done = vslow | tmo_hit;
        if (s_q.cnt != 24'hffffff)
        begin
            s_d.cnt = s_q.cnt + 24'h1;
        end

        s_d.drv.decel_cmd = 1'b0;
        s_d.drv.dyn_brake = 1'b0;

        unique case (s_q.st)
            DEBS_OFF:
            begin
                s_d.drv.power_active = 1'b0;
                s_d.drv.stopping     = 1'b0;
                s_d.drv.stop_cat     = DEBS_CATN;
                if (en_rise & ~stop_req & (s_q.flt == 3'h0)
                    & safe_torque_off_input & ~uv_f & ~fault_req)
                begin
                    s_d.st               = DEBS_RUN;
                    s_d.engaged          = 1'b0;
                    s_d.drv.power_active = 1'b1;
                end
            end
            DEBS_RUN, DEBS_DECEL:
            begin
                s_d.cnt = (s_q.st == DEBS_RUN) ? 24'h0 : s_d.cnt;
                if (go0)
                begin
                    s_d.st               = DEBS_COAST;
                    s_d.drv.power_active = 1'b0;
                    s_d.drv.stopping     = 1'b1;
                    s_d.drv.stop_cat     = DEBS_CAT0;
                    s_d.imm = s_q.ctrl[`DEBS_CTRL_BIMM]
                            & (fault_req | uv_f | sto_f | ~hw);
                    s_d.cnt              = 24'h0;
                end
                else if (f_dyn)
                begin
                    s_d.st               = DEBS_DYNBRK;
                    s_d.drv.power_active = 1'b0;
                    s_d.drv.dyn_brake    = 1'b1;
                    s_d.drv.stopping     = 1'b1;
                    s_d.drv.stop_cat     = DEBS_CAT0;
                    s_d.imm = s_q.ctrl[`DEBS_CTRL_BIMM];
                    s_d.cnt              = 24'h0;
                end
                else if (s_q.st == DEBS_DECEL)
                begin
                    s_d.drv.decel_cmd = ~done;
                    if (go1 & (s_q.drv.stop_cat == DEBS_CAT2))
                    begin
                        s_d.drv.stop_cat = DEBS_CAT1;
                    end
                    if (done)
                    begin
                        s_d.st               = DEBS_OFF;
                        s_d.drv.power_active = 1'b0;
                        s_d.engaged          = 1'b1;
                    end
                end
                else if (go1 | s_q.s2.dstop)
                begin
                    s_d.st               = DEBS_DECEL;
                    s_d.drv.decel_cmd    = 1'b1;
                    s_d.drv.stopping     = 1'b1;
                    s_d.drv.stop_cat     = go1 ? DEBS_CAT1 : DEBS_CAT2;
                    s_d.cnt              = 24'h0;
                end
            end
            DEBS_COAST, DEBS_DYNBRK:
            begin
                s_d.drv.power_active = 1'b0;
                s_d.drv.dyn_brake    = (s_q.st == DEBS_DYNBRK) & ~done;
                if (done | s_q.imm)
                begin
                    s_d.st           = DEBS_OFF;
                    s_d.engaged      = 1'b1;
                    s_d.imm          = 1'b0;
                    s_d.drv.dyn_brake = 1'b0;
                end
            end
            default:
            begin
                s_d.st = DEBS_OFF;
            end
        endcase

        s_d.drv.brake_engage = s_d.engaged
                             & s_q.ctrl[`DEBS_CTRL_BRKF];

        // Sticky faults; a new event wins over a clear
        f_new = 3'h0;
        f_new[`DEBS_FLT_UV]  = uv_f;
        f_new[`DEBS_FLT_STO] = sto_f;
        f_new[`DEBS_FLT_EXT] = fault_req;
        f_clr = 3'h0;

        // Write channel: both taken in the cycle readies stand
        s_d.awr = 1'b0;
        s_d.wr  = 1'b0;
        if (s_q.bv & s_axi_bready)
        begin
            s_d.bv = 1'b0;
        end
        if (s_q.awr)
        begin
            s_d.bv = 1'b1;
            s_d.br = 2'h0;
            unique case (s_axi_awaddr)
                `DEBS_REG_CTRL:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        s_d.ctrl = s_axi_wdata[5:0];
                    end
                end
                `DEBS_REG_VTHR:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        s_d.vthr[7:0] = s_axi_wdata[7:0];
                    end
                    if (s_axi_wstrb[1])
                    begin
                        s_d.vthr[15:8] = s_axi_wdata[15:8];
                    end
                end
                `DEBS_REG_TMO:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        s_d.tmo[7:0] = s_axi_wdata[7:0];
                    end
                    if (s_axi_wstrb[1])
                    begin
                        s_d.tmo[15:8] = s_axi_wdata[15:8];
                    end
                    if (s_axi_wstrb[2])
                    begin
                        s_d.tmo[23:16] = s_axi_wdata[23:16];
                    end
                end
                `DEBS_REG_FLT:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        f_clr = s_axi_wdata[2:0];
                    end
                end
                `DEBS_REG_STAT:
                begin
                    s_d.br = 2'h0;
                end
                default:
                begin
                    s_d.br = 2'h2;
                end
            endcase
        end
        else if (s_axi_awvalid & s_axi_wvalid & ~s_q.bv)
        begin
            s_d.awr = 1'b1;
            s_d.wr  = 1'b1;
        end
        s_d.flt = (s_q.flt & ~f_clr) | f_new;

        // Read channel
        rdv = 32'h0;
        rdv[2:0] = s_q.flt;
        rdv[`DEBS_STAT_WRN] = s_q.warn;
        s_d.arr = 1'b0;
        if (s_q.rv & s_axi_rready)
        begin
            s_d.rv = 1'b0;
        end
        if (s_q.arr)
        begin
            s_d.rv = 1'b1;
            s_d.rr = 2'h0;
            s_d.rd = 32'h0;
            unique case (s_axi_araddr)
                `DEBS_REG_CTRL: s_d.rd[5:0] = s_q.ctrl;
                `DEBS_REG_VTHR: s_d.rd[15:0] = s_q.vthr;
                `DEBS_REG_TMO:  s_d.rd[23:0] = s_q.tmo;
                `DEBS_REG_FLT:  s_d.rd = rdv;
                `DEBS_REG_STAT:
                begin
                    s_d.rd[2:0]   = s_q.st;
                    s_d.rd[6:4]   = {s_q.drv.stopping, s_q.drv.stop_cat};
                    s_d.rd[11:8]  = {s_q.drv.power_active,
                                     s_q.drv.decel_cmd,
                                     s_q.drv.dyn_brake,
                                     s_q.drv.brake_engage};
                    s_d.rd[18:16] = s_q.flt;
                    s_d.rd[19]    = s_q.warn;
                end
                default: s_d.rr = 2'h2;
            endcase
        end
        else if (s_axi_arvalid & ~s_q.rv)
        begin
            s_d.arr = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q                  <= '0;
            s_q.st               <= DEBS_OFF;
            s_q.engaged          <= 1'b1;
            s_q.drv.brake_engage <= 1'b1;
            s_q.drv.stop_cat     <= DEBS_CATN;
            s_q.ctrl             <= `DEBS_CTRL_RST;
            s_q.vthr             <= `DEBS_VTHR_RST;
            s_q.tmo              <= 24'(`DEBS_TMO_RST);
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign drv           = s_q.drv;
    assign s_axi_awready = s_q.awr;
    assign s_axi_wready  = s_q.wr;
    assign s_axi_bvalid  = s_q.bv;
    assign s_axi_bresp   = s_q.br;
    assign s_axi_arready = s_q.arr;
    assign s_axi_rvalid  = s_q.rv;
    assign s_axi_rdata   = s_q.rd;
    assign s_axi_rresp   = s_q.rr;

endmodule // debs_sequencer

// *** debs_sequencer_props.sv ***
// Concurrent checks on the sequencer's drive outputs
`timescale 1ns/1ns

module debs_sequencer_props
    import debs_pkg::*;
(
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Drive side
    input wire debs_pins_t pins_in,
    input wire logic       fault_req,
    input wire logic [1:0] fault_class,
    input wire debs_drv_t  drv
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************
    // Stop sequences
    // ****************
    sequence s_ctl_end;
        $past(drv.decel_cmd) && !drv.decel_cmd && !drv.power_active
            && drv.stop_cat != DEBS_CAT0;
    endsequence
    sequence s_sto_open;
        !pins_in.safe_torque_off_input [*5];
    endsequence
    sequence s_hw_low;
        !pins_in.hw_en [*5];
    endsequence

    property p_ctl_brake;
        s_ctl_end |-> drv.brake_engage;
    endproperty
    property p_sto_off;
        s_sto_open |-> !drv.power_active;
    endproperty
    property p_hw_off;
        s_hw_low |-> !drv.power_active;
    endproperty
    property p_estop;
        pins_in.cat0 [*5] |-> !drv.power_active && !drv.decel_cmd;
    endproperty
    property p_stop_wins;
        (pins_in.cat1 || pins_in.dstop) [*6] |-> !$rose(drv.power_active);
    endproperty
    property p_decel_pow;
        drv.decel_cmd |-> drv.power_active && drv.stopping;
    endproperty
    property p_cat_rep;
        drv.stopping |-> drv.stop_cat != DEBS_CATN;
    endproperty
    property p_dyn;
        drv.dyn_brake |-> !drv.power_active && !drv.brake_engage;
    endproperty
    property p_flt0;
        (fault_req && fault_class == 2'h0) |-> ##[1:2] !drv.power_active;
    endproperty

    a_ctl_brake: assert property (p_ctl_brake)
        else $error("brake late after controlled stop");
    a_sto_off: assert property (p_sto_off)
        else $error("power on with torque-off open");
    a_hw_off: assert property (p_hw_off)
        else $error("power on with hardware_enable_input low");
    a_estop: assert property (p_estop)
        else $error("emergency stop not dominant");
    a_stop_wins: assert property (p_stop_wins)
        else $error("enable accepted during stop");
    a_decel_pow: assert property (p_decel_pow)
        else $error("power lost during deceleration");
    a_cat_rep: assert property (p_cat_rep)
        else $error("stop without category");
    a_dyn: assert property (p_dyn)
        else $error("dynamic braking with power or brake");
    a_flt0: assert property (p_flt0)
        else $error("immediate fault kept power");
endmodule // debs_sequencer_props

// *** debs_host_model.sv ***
// Host and safety controller model with a simple motor speed
`timescale 1ns/1ns

module debs_host_model
    import debs_pkg::*;
(
    // Clock
    input  wire logic        aclk,
    // Bench requests and drive state
    input  wire debs_pins_t  want,
    input  wire logic [15:0] speed,
    input  wire logic [15:0] decay,
    input  wire debs_drv_t   drv,
    // Pins and measured speed
    output debs_pins_t       pins_in,
    output logic [15:0]      velocity
);
    initial
    begin
        pins_in = 6'h10;
        velocity = 16'h0000;
    end

    // Stop levels stay up while requested; enable rises only on request
    always @(posedge aclk)
    begin
        pins_in <= want;
        if (drv.power_active && !drv.decel_cmd)
            velocity <= speed;
        else
            velocity <= (velocity > decay) ? velocity - decay : 16'h0000;
    end
endmodule // debs_host_model

// *** debs_sequencer_tb.sv ***
// Self-checking bench for the drive enable and brake sequencer
`timescale 1ns/1ns

module debs_sequencer_tb
    import debs_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    debs_pins_t  want = 6'h10;
    debs_pins_t  pins_in;
    logic [15:0] velocity;
    logic [15:0] speed = 16'h0200;
    logic [15:0] decay = 16'h0010;
    logic        fault_req = 1'b0;
    logic [1:0]  fault_class = 2'h0;
    debs_drv_t   drv;
    int          bad_count = 0;
    int          n_compared = 0;
    int          seed = 32'h647d;
    int          n;
    int          cat_e[10] = '{2, 1, 0, 0, 0, 1, 0, 0, 1, 0};

    always #5 aclk = ~aclk;

    debs_sequencer dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pins_in, .velocity, .fault_req,
        .fault_class, .drv
    );

    debs_host_model u_host (
        .aclk, .want, .speed, .decay, .drv, .pins_in, .velocity
    );

    // ****************
    // Tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] rsp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, rsp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] rsp,
                      input string what);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(what, s_axi_rdata & m, e);
        chk("rresp", s_axi_rresp, rsp);
    endtask

    task automatic go(input logic [31:0] ctrl, input logic exp);
        // Hardware_enable_input low first, so a software enable edge cannot start it
        want.hw_en <= 1'b0;
        cyc(3);
        wr(8'h00, ctrl, 2'h0);
        cyc(2);
        want.hw_en <= 1'b1;
        cyc(6);
        chk("power on", drv.power_active, exp);
    endtask

    task automatic brk_wait();
        n = 0;
        while (drv.brake_engage !== 1'b1 && n < 400)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    // ****************
    // Scenarios
    // ****************
    initial
    begin
        cyc(4);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("drv reset", drv, 32'h0000000b);
        rd(8'h00, 32'hffffffff, 32'h24, 2'h0, "ctrl");
        rd(8'h04, 32'hffffffff, 32'h10, 2'h0, "vthr");
        rd(8'h08, 32'hffffffff, 32'h186a0, 2'h0, "tmo");
        rd(8'h14, 32'h0, 32'h0, 2'h2, "unmapped");
        wr(8'h14, 32'h0, 2'h2);
        want.safe_torque_off_input <= 1'b0;
        go(32'h25, 1'b0);
        rd(8'h10, 32'h2, 32'h2, 2'h0, "sto fault");
        want.safe_torque_off_input <= 1'b1;
        wr(8'h10, 32'h7, 2'h0);
        want.dstop <= 1'b1;
        go(32'h35, 1'b0);
        want.dstop <= 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            speed <= 16'h0200 + 16'($random(seed) & 32'h1ff);
            fault_class <= 2'(i - 6);
            go(i == 4 ? 32'h25 : 32'h35, 1'b1);
            case (i)
                0: want.dstop <= 1'b1;
                1: want.cat1 <= 1'b1;
                2: want.hw_en <= 1'b0;
                3: want <= want | 6'h06;
                4, 5: wr(8'h00, i == 4 ? 32'h24 : 32'h34, 2'h0);
                9: want.safe_torque_off_input <= 1'b0;
                default: fault_req <= 1'b1;
            endcase
            cyc(5);
            chk("cat", drv.stop_cat, cat_e[i]);
            chk("power", drv.power_active, cat_e[i] != 0);
            chk("decel", drv.decel_cmd, cat_e[i] != 0);
            chk("dyn", drv.dyn_brake, i == 7);
            chk("brake early", drv.brake_engage, 1'b0);
            chk("stopping", drv.stopping, 1'b1);
            rd(8'h0c, 32'h70, {25'h0, 1'b1, 2'(cat_e[i]), 4'h0}, 2'h0,
               "stat");
            brk_wait();
            chk("vel low", velocity < 16'h0010, 1'b1);
            chk("off", drv.power_active, 1'b0);
            rd(8'h10, 32'h6, {29'h0, i > 5 && i < 9, i == 9, 1'b0}, 2'h0,
               "fault");
            want <= (want & 6'h20) | 6'h10;
            fault_req <= 1'b0;
            wr(8'h10, 32'h7, 2'h0);
            cyc(6);
            chk("no restart", drv.power_active, 1'b0);
        end
        decay <= 16'h0000;
        go(32'h27, 1'b1);
        want.hw_en <= 1'b0;
        brk_wait();
        chk("imm", n <= 6, 1'b1);
        wr(8'h08, 32'd20, 2'h0);
        go(32'h25, 1'b1);
        want.hw_en <= 1'b0;
        brk_wait();
        chk("tmo", n >= 20 && n <= 30, 1'b1);
        want.uv <= 1'b1;
        cyc(6);
        rd(8'h10, 32'h101, 32'h100, 2'h0, "uv warn");
        want.hw_en <= 1'b1;
        cyc(6);
        rd(8'h10, 32'h1, 32'h1, 2'h0, "uv en");
        chk("uv off", drv.power_active, 1'b0);
        want <= 6'h10;
        wr(8'h00, 32'h21, 2'h0);
        wr(8'h10, 32'h7, 2'h0);
        rd(8'h10, 32'h7, 32'h0, 2'h0, "cleared");
        want.uv <= 1'b1;
        cyc(6);
        rd(8'h10, 32'h1, 32'h1, 2'h0, "uv m0");
        conclude();
    end

    initial
    begin
        #200000;
        bad_count++;
        conclude();
    end
endmodule // debs_sequencer_tb

bind debs_sequencer debs_sequencer_props u_props (
    .aclk, .aresetn, .pins_in, .fault_req, .fault_class, .drv
);
